// >>> rtl/uav_pkg.sv
package uav_pkg;

    // ------------------------------------------------------------------
    // Vector locations in code space
    // ------------------------------------------------------------------
    localparam logic [15:0] USB_JUMP_ADDR = 16'h0043;
    localparam logic [15:0] USB_PAGE_ADDR = 16'h0044;
    localparam logic [15:0] USB_VEC_ADDR = 16'h0045;
    localparam logic [15:0] FIFO_JUMP_ADDR = 16'h0053;
    localparam logic [15:0] FIFO_PAGE_ADDR = 16'h0054;
    localparam logic [15:0] FIFO_VEC_ADDR = 16'h0055;

    // ------------------------------------------------------------------
    // Source counts and vector bases
    // ------------------------------------------------------------------
    localparam int USB_SRC_N = 27;
    localparam int FIFO_SRC_N = 14;
    localparam logic [7:0] USB_VEC_BASE = 8'h00;
    localparam logic [7:0] FIFO_VEC_BASE = 8'h80;
    localparam logic [7:0] VEC_STEP = 8'h04;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] FIFO_VEC_RESET = 8'h80;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // USB source index to vector code; reserved slots are skipped, except 8'h64, which is kept as the 27th entry
    localparam logic [7:0] USB_CODE [USB_SRC_N] = '{
        8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18,
        8'h20, 8'h24, 8'h28, 8'h2C,
        8'h30, 8'h34, 8'h38, 8'h3C,
        8'h40,
        8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C,
        8'h60,
        8'h70, 8'h74, 8'h78, 8'h7C,
        8'h64
    };

endpackage : uav_pkg

// >>> rtl/uav_prio_enc.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Priority encoder: lowest set index wins
// ----------------------------------------------------------------------
module uav_prio_enc #(
    parameter int N = 27,
    parameter int W = 5
) (
    input wire logic [N-1:0] req_in,
    output logic [W-1:0] idx_out,
    output logic any_out
);
    always_comb begin
        idx_out = '0;
        any_out = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                idx_out = W'(i);
                any_out = 1'b1;
            end
        end
    end
endmodule : uav_prio_enc

// >>> rtl/uav_autovector.sv
`timescale 1ns/1ps
module uav_autovector (
    input wire logic clock_in,
    input wire logic rst_b_in,
    // USB sources, bit order is priority order (bit 0 best)
    input wire logic [25:0] usb_src_in,
    input wire logic [13:0] fifo_src_in,
    input wire logic usb_autovector_enable_in,
    input wire logic fifo_autovector_enable_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic fetch_valid_in,
    input wire logic [7:0] mem_data_in,
    output logic usb_shared_irq_out,
    output logic fifo_shared_irq_out,
    output logic [7:0] usb_vector_byte_out,
    output logic [7:0] fifo_vector_byte_out,
    output logic [7:0] fetch_data_out,
    output logic fetch_substituted_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic usb_irq;
        logic fifo_irq;
        logic [7:0] usb_vec;
        logic [7:0] fifo_vec;
        logic [7:0] fdata;
        logic subst;
    } uav_state_t;

    uav_state_t st_ff;
    uav_state_t nxt_st;

    logic [4:0] usb_idx;
    logic usb_any;
    logic [3:0] fifo_idx;
    logic fifo_any;

    // Only 26 sources are encoded; the 27th USB_CODE entry (8'h64) is never selected
    uav_prio_enc #(.N(26), .W(5)) u_usb_enc (
        .req_in(usb_src_in),
        .idx_out(usb_idx),
        .any_out(usb_any)
    );

    uav_prio_enc #(.N(14), .W(4)) u_fifo_enc (
        .req_in(fifo_src_in),
        .idx_out(fifo_idx),
        .any_out(fifo_any)
    );

    function automatic logic [7:0] fifo_code(input logic [3:0] idx);
        fifo_code = uav_pkg::FIFO_VEC_BASE + 8'({idx, 2'b00});
    endfunction : fifo_code

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.usb_irq = usb_any;
        nxt_st.fifo_irq = fifo_any;
        // Vector holds the best pending source; unchanged when idle
        if (usb_any) begin
            nxt_st.usb_vec = uav_pkg::USB_CODE[usb_idx];
        end
        if (fifo_any) begin
            nxt_st.fifo_vec = fifo_code(fifo_idx);
        end
        nxt_st.fdata = mem_data_in;
        nxt_st.subst = 1'b0;
        // Jump opcodes and page bytes always come from memory
        if (fetch_valid_in && usb_autovector_enable_in &&
            fetch_addr_in == uav_pkg::USB_VEC_ADDR) begin
            nxt_st.fdata = st_ff.usb_vec;
            nxt_st.subst = 1'b1;
        end
        if (fetch_valid_in && fifo_autovector_enable_in &&
            fetch_addr_in == uav_pkg::FIFO_VEC_ADDR) begin
            nxt_st.fdata = st_ff.fifo_vec;
            nxt_st.subst = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '{usb_irq: 1'b0, fifo_irq: 1'b0,
                       usb_vec: uav_pkg::VEC_RESET,
                       fifo_vec: uav_pkg::FIFO_VEC_RESET,
                       fdata: uav_pkg::DATA_RESET, subst: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign usb_shared_irq_out = st_ff.usb_irq;
    assign fifo_shared_irq_out = st_ff.fifo_irq;
    assign usb_vector_byte_out = st_ff.usb_vec;
    assign fifo_vector_byte_out = st_ff.fifo_vec;
    assign fetch_data_out = st_ff.fdata;
    assign fetch_substituted_out = st_ff.subst;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_usb_irq;
        @(posedge clock_in) disable iff (!rst_b_in)
        (|usb_src_in) |=> usb_shared_irq_out;
    endproperty
    a_usb_irq: assert property (p_usb_irq) else $error("usb irq missing");

    property p_fifo_irq;
        @(posedge clock_in) disable iff (!rst_b_in)
        !(|fifo_src_in) |=> !fifo_shared_irq_out;
    endproperty
    a_fifo_irq: assert property (p_fifo_irq) else $error("fifo irq stuck");

    property p_usb_top;
        @(posedge clock_in) disable iff (!rst_b_in)
        usb_src_in[0] |=> usb_vector_byte_out == 8'h00;
    endproperty
    a_usb_top: assert property (p_usb_top) else $error("setup not top");

    property p_usb_ack;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[5:0] == 6'h20) |=> usb_vector_byte_out == 8'h18;
    endproperty
    a_usb_ack: assert property (p_usb_ack) else $error("ack code wrong");

    property p_usb_nak;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[14:0] == 15'h4000) |=> usb_vector_byte_out == 8'h40;
    endproperty
    a_usb_nak: assert property (p_usb_nak) else $error("nak code wrong");

    property p_usb_err;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[21:0] == 22'h200000) |=> usb_vector_byte_out == 8'h60;
    endproperty
    a_usb_err: assert property (p_usb_err) else $error("limit code wrong");

    property p_no_resv;
        @(posedge clock_in) disable iff (!rst_b_in)
        usb_vector_byte_out != 8'h14 && usb_vector_byte_out != 8'h1C &&
        usb_vector_byte_out != 8'h44 && usb_vector_byte_out != 8'h64 &&
        usb_vector_byte_out != 8'h68 && usb_vector_byte_out != 8'h6C;
    endproperty
    a_no_resv: assert property (p_no_resv) else $error("reserved code");

    property p_fifo_last;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in == 14'h2000) |=> fifo_vector_byte_out == 8'hB4;
    endproperty
    a_fifo_last: assert property (p_fifo_last) else $error("event code wrong");

    property p_fifo_full;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in[11:0] == 12'h100) |=> fifo_vector_byte_out == 8'hA0;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("full code wrong");

    property p_usb_sub;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fetch_valid_in && usb_autovector_enable_in && fetch_addr_in == 16'h0045)
        |=> fetch_data_out == $past(usb_vector_byte_out) && fetch_substituted_out;
    endproperty
    a_usb_sub: assert property (p_usb_sub) else $error("usb substitute");

    property p_fifo_sub;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fetch_valid_in && fifo_autovector_enable_in && fetch_addr_in == 16'h0055)
        |=> fetch_data_out == $past(fifo_vector_byte_out) && fetch_substituted_out;
    endproperty
    a_fifo_sub: assert property (p_fifo_sub) else $error("fifo substitute");

    property p_pass;
        @(posedge clock_in) disable iff (!rst_b_in)
        (!usb_autovector_enable_in && !fifo_autovector_enable_in)
        |=> fetch_data_out == $past(mem_data_in) && !fetch_substituted_out;
    endproperty
    a_pass: assert property (p_pass) else $error("passthrough broken");

    property p_usb_irq_low;
        @(posedge clock_in) disable iff (!rst_b_in)
        !(|usb_src_in) |=> !usb_shared_irq_out;
    endproperty
    a_usb_irq_low: assert property (p_usb_irq_low) else $error("usb irq stuck");

    property p_fifo_irq_high;
        @(posedge clock_in) disable iff (!rst_b_in)
        (|fifo_src_in) |=> fifo_shared_irq_out;
    endproperty
    a_fifo_irq_high: assert property (p_fifo_irq_high) else $error("fifo irq missing");

    property p_usb_frame;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[1:0] == 2'b10) |=> usb_vector_byte_out == 8'h04;
    endproperty
    a_usb_frame: assert property (p_usb_frame) else $error("frame code wrong");

    property p_usb_ep0_in;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[6:0] == 7'h40) |=> usb_vector_byte_out == 8'h20;
    endproperty
    a_usb_ep0_in: assert property (p_usb_ep0_in) else $error("ep0 in code wrong");

    property p_usb_ep2;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[10:0] == 11'h400) |=> usb_vector_byte_out == 8'h30;
    endproperty
    a_usb_ep2: assert property (p_usb_ep2) else $error("ep2 code wrong");

    property p_usb_ep8;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[13:0] == 14'h2000) |=> usb_vector_byte_out == 8'h3C;
    endproperty
    a_usb_ep8: assert property (p_usb_ep8) else $error("ep8 code wrong");

    property p_usb_ping0;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[15:0] == 16'h8000) |=> usb_vector_byte_out == 8'h48;
    endproperty
    a_usb_ping0: assert property (p_usb_ping0) else $error("ping0 code wrong");

    property p_usb_ping8;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[20:0] == 21'h100000) |=> usb_vector_byte_out == 8'h5C;
    endproperty
    a_usb_ping8: assert property (p_usb_ping8) else $error("ping8 code wrong");

    property p_usb_iso2;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in[22:0] == 23'h400000) |=> usb_vector_byte_out == 8'h70;
    endproperty
    a_usb_iso2: assert property (p_usb_iso2) else $error("iso2 code wrong");

    property p_usb_iso8;
        @(posedge clock_in) disable iff (!rst_b_in)
        (usb_src_in == 26'h2000000) |=> usb_vector_byte_out == 8'h7C;
    endproperty
    a_usb_iso8: assert property (p_usb_iso8) else $error("iso8 code wrong");

    property p_fifo_top;
        @(posedge clock_in) disable iff (!rst_b_in)
        fifo_src_in[0] |=> fifo_vector_byte_out == 8'h80;
    endproperty
    a_fifo_top: assert property (p_fifo_top) else $error("level flag not top");

    property p_fifo_empty2;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in[4:0] == 5'h10) |=> fifo_vector_byte_out == 8'h90;
    endproperty
    a_fifo_empty2: assert property (p_fifo_empty2) else $error("empty2 code wrong");

    property p_fifo_empty8;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in[7:0] == 8'h80) |=> fifo_vector_byte_out == 8'h9C;
    endproperty
    a_fifo_empty8: assert property (p_fifo_empty8) else $error("empty8 code wrong");

    property p_fifo_full8;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in[11:0] == 12'h800) |=> fifo_vector_byte_out == 8'hAC;
    endproperty
    a_fifo_full8: assert property (p_fifo_full8) else $error("full8 code wrong");

    property p_fifo_done;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fifo_src_in[12:0] == 13'h1000) |=> fifo_vector_byte_out == 8'hB0;
    endproperty
    a_fifo_done: assert property (p_fifo_done) else $error("done code wrong");

    property p_usb_hold;
        @(posedge clock_in) disable iff (!rst_b_in)
        !(|usb_src_in) |=> $stable(usb_vector_byte_out);
    endproperty
    a_usb_hold: assert property (p_usb_hold) else $error("usb vector moved");

    property p_fifo_hold;
        @(posedge clock_in) disable iff (!rst_b_in)
        !(|fifo_src_in) |=> $stable(fifo_vector_byte_out);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("fifo vector moved");

    // Opcode and page bytes must never be replaced, whatever the enables say
    property p_jump_pass;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fetch_valid_in && (fetch_addr_in == uav_pkg::USB_JUMP_ADDR ||
            fetch_addr_in == uav_pkg::USB_PAGE_ADDR ||
            fetch_addr_in == uav_pkg::FIFO_JUMP_ADDR ||
            fetch_addr_in == uav_pkg::FIFO_PAGE_ADDR))
        |=> fetch_data_out == $past(mem_data_in) && !fetch_substituted_out;
    endproperty
    a_jump_pass: assert property (p_jump_pass) else $error("jump byte altered");

    property p_usb_off;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fetch_valid_in && !usb_autovector_enable_in &&
            fetch_addr_in == uav_pkg::USB_VEC_ADDR)
        |=> fetch_data_out == $past(mem_data_in) && !fetch_substituted_out;
    endproperty
    a_usb_off: assert property (p_usb_off) else $error("usb vector forced");

    property p_fifo_off;
        @(posedge clock_in) disable iff (!rst_b_in)
        (fetch_valid_in && !fifo_autovector_enable_in &&
            fetch_addr_in == uav_pkg::FIFO_VEC_ADDR)
        |=> fetch_data_out == $past(mem_data_in) && !fetch_substituted_out;
    endproperty
    a_fifo_off: assert property (p_fifo_off) else $error("fifo vector forced");

    property p_subst_src;
        @(posedge clock_in) disable iff (!rst_b_in)
        fetch_substituted_out |-> $past(fetch_valid_in);
    endproperty
    a_subst_src: assert property (p_subst_src) else $error("substitute without fetch");

    c_usb_sub: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        fetch_substituted_out && fetch_data_out < 8'h80);
    c_fifo_sub: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        fetch_substituted_out && fetch_data_out >= 8'h80);
    c_both_irq: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        usb_shared_irq_out && fifo_shared_irq_out);
    c_usb_off: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        fetch_valid_in && !usb_autovector_enable_in && fetch_addr_in == uav_pkg::USB_VEC_ADDR);
    c_vec_hold: cover property (@(posedge clock_in) disable iff (!rst_b_in)
        !usb_shared_irq_out && usb_vector_byte_out != uav_pkg::VEC_RESET);

endmodule : uav_autovector

// >>> verification/uav_core_model.sv
`timescale 1ns/1ps
// -----
// Processor core fetch model
// -----
module uav_core_model #(
    parameter logic [7:0] JUMP_OP = 8'h02,
    parameter logic [7:0] USB_PAGE = 8'h12,
    parameter logic [7:0] FIFO_PAGE = 8'h13,
    parameter logic [7:0] FILL = 8'h5A
) (
    input wire logic clock_in,
    input wire logic [7:0] fetch_data_in,
    input wire logic fetch_substituted_in,
    output logic [15:0] fetch_addr_out,
    output logic fetch_valid_out,
    output logic [7:0] mem_data_out
);
    initial begin
        fetch_addr_out = 16'h0000;
        fetch_valid_out = 1'b0;
        mem_data_out = 8'h00;
    end

    // Released lines show the inverse so a stale byte cannot pass
    task automatic fetch(input logic [15:0] a, input logic [7:0] m,
                         output logic [7:0] d, output logic s);
        @(negedge clock_in);
        fetch_addr_out <= a;
        fetch_valid_out <= 1'b1;
        mem_data_out <= m;
        @(negedge clock_in);
        fetch_valid_out <= 1'b0;
        fetch_addr_out <= ~a;
        mem_data_out <= ~m;
        d = fetch_data_in;
        s = fetch_substituted_in;
    endtask : fetch

    task automatic take_irq(input logic fifo, output logic [7:0] op, pg, vec,
                            output logic sub, stray);
        logic [15:0] base;
        logic s0;
        logic s1;
        base = fifo ? 16'h0053 : 16'h0043;
        fetch(base, JUMP_OP, op, s0);
        fetch(base + 16'h0001, fifo ? FIFO_PAGE : USB_PAGE, pg, s1);
        fetch(base + 16'h0002, FILL, vec, sub);
        // Opcode or page byte flagged as substituted is a fault
        stray = s0 | s1;
    endtask : take_irq
endmodule : uav_core_model

// >>> verification/uav_autovector_tb_top.sv
`timescale 1ns/1ps
module uav_autovector_tb_top;
    localparam logic [7:0] USB_EXP [26] = '{
        8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
        8'h34, 8'h38, 8'h3C, 8'h40, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60,
        8'h70, 8'h74, 8'h78, 8'h7C};
    localparam logic [7:0] FIFO_EXP [14] = '{
        8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hA4, 8'hA8,
        8'hAC, 8'hB0, 8'hB4};
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [25:0] usb_src = '0;
    logic [13:0] fifo_src = '0;
    logic usb_en = 1'b1;
    logic fifo_en = 1'b1;
    logic [15:0] f_addr;
    logic f_valid, usb_irq, fifo_irq, f_sub, sub, stray;
    logic [7:0] m_data, usb_vec, fifo_vec, f_data, op, pg, vec;
    int failures = 0;
    int samples_checked = 0;

    uav_autovector i_uav_autovector (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .usb_src_in(usb_src), .fifo_src_in(fifo_src),
        .usb_autovector_enable_in(usb_en), .fifo_autovector_enable_in(fifo_en),
        .fetch_addr_in(f_addr), .fetch_valid_in(f_valid), .mem_data_in(m_data),
        .usb_shared_irq_out(usb_irq), .fifo_shared_irq_out(fifo_irq),
        .usb_vector_byte_out(usb_vec), .fifo_vector_byte_out(fifo_vec),
        .fetch_data_out(f_data), .fetch_substituted_out(f_sub));
    uav_core_model i_uav_core_model (.clock_in(clock_in), .fetch_data_in(f_data),
        .fetch_substituted_in(f_sub), .fetch_addr_out(f_addr),
        .fetch_valid_out(f_valid), .mem_data_out(m_data));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk_reset;
        chk({5'h00, usb_irq, fifo_irq, f_sub}, 8'h00);
        chk(usb_vec, 8'h00);
        chk(fifo_vec, 8'h80);
        chk(f_data, 8'h00);
    endtask : chk_reset

    // -----
    // One interrupt entry through the core model
    // -----
    task automatic irq_round(input logic fifo, input logic en, input logic [7:0] exp);
        i_uav_core_model.take_irq(fifo, op, pg, vec, sub, stray);
        chk(op, 8'h02);
        chk(pg, fifo ? 8'h13 : 8'h12);
        chk(vec, en ? exp : 8'h5A);
        chk({7'h00, sub}, {7'h00, en});
        chk({7'h00, stray}, 8'h00);
    endtask : irq_round

    initial begin
        #100000;
        failures++;
        conclude;
    end

    initial begin
        repeat (20) @(negedge clock_in);
        chk_reset;
        rst_b_in <= 1'b1;
        // Every lower-priority source stays pending too
        for (int i = 0; i < 26; i++) begin
            usb_src <= ~((26'h1 << i) - 26'h1);
            @(negedge clock_in);
            chk({7'h00, usb_irq}, 8'h01);
            chk(usb_vec, USB_EXP[i]);
            irq_round(1'b0, 1'b1, USB_EXP[i]);
        end
        for (int i = 0; i < 14; i++) begin
            fifo_src <= ~((14'h1 << i) - 14'h1);
            @(negedge clock_in);
            chk({7'h00, fifo_irq}, 8'h01);
            chk(fifo_vec, FIFO_EXP[i]);
            irq_round(1'b1, 1'b1, FIFO_EXP[i]);
        end
        // Each enable acts on its own vector location only
        usb_en <= 1'b0;
        irq_round(1'b0, 1'b0, 8'h00);
        irq_round(1'b1, 1'b1, 8'hB4);
        usb_en <= 1'b1;
        fifo_en <= 1'b0;
        irq_round(1'b0, 1'b1, 8'h7C);
        irq_round(1'b1, 1'b0, 8'h00);
        usb_en <= 1'b0;
        irq_round(1'b0, 1'b0, 8'h00);
        // Idle sources drop the requests while the vectors hold
        usb_src <= '0;
        fifo_src <= '0;
        repeat (2) @(negedge clock_in);
        chk({6'h00, usb_irq, fifo_irq}, 8'h00);
        chk(usb_vec, 8'h7C);
        chk(fifo_vec, 8'hB4);
        rst_b_in <= 1'b0;
        @(negedge clock_in);
        chk_reset;
        // Second release: the first edge after it already takes requests
        rst_b_in <= 1'b1;
        usb_en <= 1'b1;
        usb_src <= 26'h0000020;
        @(negedge clock_in);
        chk(usb_vec, 8'h18);
        irq_round(1'b0, 1'b1, 8'h18);
        conclude;
    end
endmodule : uav_autovector_tb_top
